//--- logic/pts_pkg.sv
// Package: status codes, event kinds, modes and sizes of the trace status port
package pts_pkg;

  // ------------------------------------------------------------
  // Widths and queue shape
  // ------------------------------------------------------------
  localparam int DATA_W  = 32;
  localparam int NIB_W   = 4;
  localparam int QDEPTH  = 2;
  localparam int BYTES_W = 2;
  localparam int ENTRY_W = DATA_W + BYTES_W;
  localparam int CNT_W   = 4;

  // ------------------------------------------------------------
  // Status port codes (reserved 2 and 6 have no name on purpose)
  // ------------------------------------------------------------
  localparam logic [3:0] PS_CONT   = 4'h0;
  localparam logic [3:0] PS_BEGIN  = 4'h1;
  localparam logic [3:0] PS_USER   = 4'h3;
  localparam logic [3:0] PS_PULSE  = 4'h4;
  localparam logic [3:0] PS_BRANCH = 4'h5;
  localparam logic [3:0] PS_EXCRET = 4'h7;
  localparam logic [3:0] PS_XFER1  = 4'h8;
  localparam logic [3:0] PS_XFER2  = 4'h9;
  localparam logic [3:0] PS_XFER3  = 4'ha;
  localparam logic [3:0] PS_XFER4  = 4'hb;
  localparam logic [3:0] PS_EXC    = 4'hc;
  localparam logic [3:0] PS_EMU    = 4'hd;
  localparam logic [3:0] PS_STOP   = 4'he;
  localparam logic [3:0] PS_HALT   = 4'hf;

  // ------------------------------------------------------------
  // Transfer byte counts, as carried in a queue entry
  // ------------------------------------------------------------
  localparam logic [1:0] BYTES_1 = 2'h0;
  localparam logic [1:0] BYTES_2 = 2'h1;
  localparam logic [1:0] BYTES_3 = 2'h2;
  localparam logic [1:0] BYTES_4 = 2'h3;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] DEBUG_DATA_PORT_RST  = 4'h0;

  typedef enum logic [2:0] {
    K_PLAIN  = 3'h0,
    K_PULSE  = 3'h1,
    K_WRDBG  = 3'h2,
    K_BRANCH = 3'h3,
    K_EXCRET = 3'h4
  } pts_kind_e;

  typedef enum logic [4:0] {
    M_RUN  = 5'h01,
    M_EXC  = 5'h02,
    M_EMU  = 5'h04,
    M_STOP = 5'h08,
    M_HALT = 5'h10
  } pts_mode_e;

endpackage : pts_pkg

//--- logic/pts_fifo_if.sv
// Interface: valid/ready push and pop sides of the debug data queue
`timescale 1ns/1ns
interface pts_fifo_if #(
  parameter int WIDTH = 34,
  parameter int LVL_W = 2
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  logic [LVL_W-1:0] level;

  modport src (
    output in_valid,
    input  in_ready,
    output in_data,
    input  out_valid,
    output out_ready,
    input  out_data,
    input  level
  );

  modport fifo (
    input  in_valid,
    output in_ready,
    input  in_data,
    output out_valid,
    input  out_ready,
    output out_data,
    output level
  );
endinterface : pts_fifo_if

//--- logic/pts_fifo.sv
// Module: small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module pts_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 2,
  parameter int LVL_W = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  pts_fifo_if.fifo q
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << (LVL_W - 1)) > DEPTH || (1 << LVL_W) <= DEPTH) begin : g_bad_shape
    $error("pts_fifo: DEPTH must be at least 2 and LVL_W must hold exactly 0..DEPTH");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr;
  logic [PTR_W-1:0] rptr;
  logic [LVL_W-1:0] count;

  wire do_push = q.in_valid & q.in_ready;
  wire do_pop  = q.out_valid & q.out_ready;

  wire [PTR_W-1:0] wptr_inc = (wptr == PTR_W'(DEPTH - 1)) ? '0 : wptr + 1'b1;
  wire [PTR_W-1:0] rptr_inc = (rptr == PTR_W'(DEPTH - 1)) ? '0 : rptr + 1'b1;

  // Full/empty come from the count register, never from the strobes
  assign q.in_ready  = (count != LVL_W'(DEPTH));
  assign q.out_valid = (count != '0);
  assign q.out_data  = mem[rptr];
  assign q.level     = count;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wptr <= wptr_inc;
      end
      if (do_pop) begin
        rptr <= rptr_inc;
      end
      count <= count + LVL_W'(do_push) - LVL_W'(do_pop);
    end
  end

  // Storage needs no reset; a word is only read after it was written
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wptr] <= q.in_data;
    end
  end
endmodule : pts_fifo

//--- logic/pts_trace.sv
// Module: real-time trace encoder for the processor status and debug data ports
`timescale 1ns/1ns
module pts_trace #(
  parameter int DATA_W = pts_pkg::DATA_W,
  parameter int QDEPTH = pts_pkg::QDEPTH
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              ev_valid,
  input  wire logic [2:0]        ev_kind,
  input  wire logic              ev_variant,
  input  wire logic              ev_user,
  input  wire logic [1:0]        ev_size,
  input  wire logic [DATA_W-1:0] ev_data,
  input  wire logic              exc_active,
  input  wire logic              emu_exc_active,
  input  wire logic              stopped,
  input  wire logic              halted,
  input  wire logic              cfg_show_target,
  input  wire logic [1:0]        cfg_target_bytes,
  output logic                   stall,
  output logic [3:0]             proc_status_port,
  output logic [3:0]             debug_data_port
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  localparam int ENTRY_W = DATA_W + pts_pkg::BYTES_W;
  localparam int LVL_W   = $clog2(QDEPTH + 1);
  localparam int CNT_W   = pts_pkg::CNT_W;

  if (DATA_W != pts_pkg::DATA_W || QDEPTH < 2) begin : g_bad_param
    $error("pts_trace: DATA_W must be 32 and QDEPTH at least 2");
  end

  // ------------------------------------------------------------
  // State registers, and the combinational next_mode
  // ------------------------------------------------------------
  pts_pkg::pts_mode_e next_mode;

  logic              ann;
  logic              pend_user;
  logic [CNT_W-1:0]  cnt;
  logic [DATA_W-1:0] shreg;

  // ------------------------------------------------------------
  // Data queue
  // ------------------------------------------------------------
  pts_fifo_if #(
    .WIDTH (ENTRY_W),
    .LVL_W (LVL_W)
  ) q ();

  pts_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (QDEPTH),
    .LVL_W (LVL_W)
  ) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .q        (q.fifo)
  );

  // ------------------------------------------------------------
  // Mode selection, highest priority first
  // ------------------------------------------------------------
  assign next_mode = halted         ? pts_pkg::M_HALT :
                     stopped        ? pts_pkg::M_STOP :
                     emu_exc_active ? pts_pkg::M_EMU  :
                     exc_active     ? pts_pkg::M_EXC  :
                                      pts_pkg::M_RUN;

  wire run = (next_mode == pts_pkg::M_RUN);

  // ------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------
  wire is_plain  = (ev_kind == pts_pkg::K_PLAIN);
  wire is_pulse  = (ev_kind == pts_pkg::K_PULSE);
  wire is_wrdbg  = (ev_kind == pts_pkg::K_WRDBG);
  wire is_branch = (ev_kind == pts_pkg::K_BRANCH);
  wire is_excret = (ev_kind == pts_pkg::K_EXCRET);

  // An event is taken only in a cycle where stall is low
  wire acc = ev_valid & ~stall & run;

  // Only variant targets are worth showing; fixed ones are in the image
  wire tgt_kind  = is_branch | is_excret;
  wire show_tgt  = tgt_kind & ev_variant & cfg_show_target;
  wire needs     = is_wrdbg | show_tgt;

  // A byte count of one makes no sense for an address; it falls back to two
  wire [1:0] tgt_bytes = (cfg_target_bytes == pts_pkg::BYTES_1) ? pts_pkg::BYTES_2
                                                                 : cfg_target_bytes;
  wire [1:0] push_bytes = is_wrdbg ? ev_size : tgt_bytes;

  wire [3:0] prim_code =
    is_pulse  ? pts_pkg::PS_PULSE  :
    is_wrdbg  ? pts_pkg::PS_PULSE  :
    is_branch ? pts_pkg::PS_BRANCH :
    is_excret ? pts_pkg::PS_EXCRET :
    is_plain  ? pts_pkg::PS_BEGIN  :
                pts_pkg::PS_BEGIN;

  // ------------------------------------------------------------
  // Queue push and pop
  // ------------------------------------------------------------
  wire push = acc & needs;
  wire pop  = ann;

  assign q.in_valid  = push;
  assign q.in_data   = {push_bytes, ev_data};
  assign q.out_ready = pop;

  wire [1:0]        head_bytes = q.out_data[ENTRY_W-1:DATA_W];
  wire [DATA_W-1:0] head_data  = q.out_data[DATA_W-1:0];

  // Nibbles in the head entry: twice the byte count
  wire [CNT_W-1:0] head_nibs = CNT_W'({2'b00, head_bytes} + 4'h1) << 1;

  wire [LVL_W:0] lvl_ext    = {1'b0, q.level};
  wire [LVL_W:0] count_next = lvl_ext + (LVL_W + 1)'(push) - (LVL_W + 1)'(pop);

  wire q_nonempty_next = (count_next != '0);
  wire q_full_next     = (count_next == (LVL_W + 1)'(QDEPTH));

  // ------------------------------------------------------------
  // Serializer counter
  // ------------------------------------------------------------
  wire [CNT_W-1:0] next_cnt = ann        ? head_nibs - 1'b1 :
                              (cnt != '0) ? cnt - 1'b1       :
                                            '0;

  // ------------------------------------------------------------
  // Announce: byte-count code goes out when the serializer is free,
  // so its first nibble follows on the very next cycle
  // ------------------------------------------------------------
  wire next_ann = ~acc & run & q_nonempty_next & (next_cnt == '0);

  wire [3:0] xfer_code = (head_bytes == pts_pkg::BYTES_1) ? pts_pkg::PS_XFER1 :
                         (head_bytes == pts_pkg::BYTES_2) ? pts_pkg::PS_XFER2 :
                         (head_bytes == pts_pkg::BYTES_3) ? pts_pkg::PS_XFER3 :
                                                            pts_pkg::PS_XFER4;

  // ------------------------------------------------------------
  // User-mode entry is one extra code after the instruction
  // ------------------------------------------------------------
  wire user_go        = ~acc & run & ~next_ann & pend_user;
  wire next_pend_user = (pend_user & ~user_go) | (acc & ev_user);

  // ------------------------------------------------------------
  // Status code for the next cycle
  // ------------------------------------------------------------
  logic [3:0] next_status;

  always_comb begin
    case (next_mode)
      pts_pkg::M_HALT: begin
        next_status = pts_pkg::PS_HALT;
      end
      pts_pkg::M_STOP: begin
        next_status = pts_pkg::PS_STOP;
      end
      pts_pkg::M_EMU: begin
        next_status = pts_pkg::PS_EMU;
      end
      pts_pkg::M_EXC: begin
        next_status = pts_pkg::PS_EXC;
      end
      pts_pkg::M_RUN: begin
        if (acc) begin
          next_status = prim_code;
        end else if (next_ann) begin
          next_status = xfer_code;
        end else if (user_go) begin
          next_status = pts_pkg::PS_USER;
        end else begin
          next_status = pts_pkg::PS_CONT;
        end
      end
      default: begin
        next_status = pts_pkg::PS_CONT;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Stall: a slot is kept free for a pending code, and the core
  // waits while the queue has no room
  // ------------------------------------------------------------
  wire head_wait  = q_nonempty_next & (next_cnt == '0) & ~next_ann;
  wire next_stall = next_pend_user | head_wait | q_full_next;

  // ------------------------------------------------------------
  // Debug data nibble for the next cycle
  // ------------------------------------------------------------
  wire [3:0] next_debug_data_port = ann         ? head_data[3:0] :
                          (cnt != '0) ? shreg[3:0]     :
                                        pts_pkg::DEBUG_DATA_PORT_RST;

  wire [DATA_W-1:0] next_shreg = ann ? (head_data >> 4) : (shreg >> 4);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      proc_status_port <= pts_pkg::STATUS_RST;
      stall            <= 1'b0;
      ann              <= 1'b0;
      pend_user        <= 1'b0;
    end else begin
      proc_status_port <= next_status;
      stall            <= next_stall;
      ann              <= next_ann;
      pend_user        <= next_pend_user;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt             <= '0;
      shreg           <= '0;
      debug_data_port <= pts_pkg::DEBUG_DATA_PORT_RST;
    end else begin
      cnt             <= next_cnt;
      shreg           <= next_shreg;
      debug_data_port <= next_debug_data_port;
    end
  end

endmodule : pts_trace

//--- dv/pts_trace_asserts.sv
// Checker: status codes against the core inputs that cause them
`timescale 1ns/1ns
module pts_trace_asserts (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       ev_valid,
  input wire logic [2:0] ev_kind,
  input wire logic       ev_user,
  input wire logic       exc_active,
  input wire logic       emu_exc_active,
  input wire logic       stopped,
  input wire logic       halted,
  input wire logic       stall,
  input wire logic [3:0] proc_status_port
);
  wire modes = halted || stopped || emu_exc_active || exc_active;
  wire taken = ev_valid && !stall && !modes;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_no_reserved: assert property (!(proc_status_port inside {4'h2, 4'h6}))
    else $error("reserved status code driven");
  a_halt_code: assert property (halted [*2] |-> proc_status_port == pts_pkg::PS_HALT)
    else $error("halted code missing");
  a_stop_code: assert property (stopped && !halted |=> proc_status_port == pts_pkg::PS_STOP)
    else $error("stopped code missing");
  a_emu_code: assert property (emu_exc_active && !stopped && !halted
    |=> proc_status_port == pts_pkg::PS_EMU)
    else $error("emulator exception code missing");
  a_exc_code: assert property (exc_active && !emu_exc_active && !stopped && !halted
    |=> proc_status_port == pts_pkg::PS_EXC)
    else $error("exception code missing");
  a_begin_code: assert property (taken && ev_kind == 3'h0 |=> proc_status_port == pts_pkg::PS_BEGIN)
    else $error("begin code missing");
  a_pulse_code: assert property (taken && ev_kind inside {3'h1, 3'h2}
    |=> proc_status_port == pts_pkg::PS_PULSE)
    else $error("trigger code missing");
  a_branch_code: assert property (taken && ev_kind == 3'h3 |=> proc_status_port == pts_pkg::PS_BRANCH)
    else $error("taken branch code missing");
  a_excret_code: assert property (taken && ev_kind == 3'h4 |=> proc_status_port == pts_pkg::PS_EXCRET)
    else $error("exception return code missing");
  a_user_entry: assert property (taken && ev_user |=> ##[1:6] proc_status_port == pts_pkg::PS_USER)
    else $error("user entry code missing");
endmodule : pts_trace_asserts

bind pts_trace pts_trace_asserts u_chk (.core_clk(core_clk), .rst(rst), .ev_valid(ev_valid), .ev_kind(ev_kind),
  .ev_user(ev_user), .exc_active(exc_active), .emu_exc_active(emu_exc_active), .stopped(stopped),
  .halted(halted), .stall(stall), .proc_status_port(proc_status_port));

//--- dv/pts_analyzer.sv
// Partner: trace analyzer that rebuilds each transfer from the two ports
`timescale 1ns/1ns
module pts_analyzer (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [3:0] proc_status_port,
  input  wire logic [3:0] debug_data_port,
  output logic            got_valid,
  output logic [31:0]     got_data,
  output logic [2:0]      got_bytes
);
  logic [3:0]  left;
  logic [4:0]  idx;
  logic [2:0]  nb;
  logic [31:0] acc;
  wire         announce = proc_status_port[3:2] == 2'b10;
  wire         last     = left == 4'h1;
  wire [31:0]  nib      = 32'(debug_data_port) << (idx * 4);

  // Announce one cycle ahead, then low nibble first, two per byte
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      left      <= 4'h0;
      idx       <= 5'h0;
      nb        <= 3'h0;
      acc       <= 32'h0;
      got_valid <= 1'b0;
      got_data  <= 32'h0;
      got_bytes <= 3'h0;
    end else begin
      got_valid <= last;
      if (left != 4'h0) begin
        acc  <= acc | nib;
        idx  <= idx + 5'h1;
        left <= left - 4'h1;
      end
      if (last) begin
        got_data  <= acc | nib;
        got_bytes <= nb;
      end
      if ((left == 4'h0 || last) && announce) begin
        nb   <= 3'(proc_status_port[1:0]) + 3'h1;
        left <= 4'(proc_status_port[1:0]) * 4'h2 + 4'h2;
        idx  <= 5'h0;
        acc  <= 32'h0;
      end
    end
  end
endmodule : pts_analyzer

//--- dv/processor_trace_status_port_bench.sv
// Testbench: random and corner traffic through the trace encoder
`timescale 1ns/1ns
module processor_trace_status_port_bench;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ev_valid = 1'b0;
  logic [2:0]  ev_kind = 3'h0;
  logic        ev_variant = 1'b0;
  logic        ev_user = 1'b0;
  logic [1:0]  ev_size = 2'h0;
  logic [31:0] ev_data = 32'h0;
  logic [3:0]  lvl = 4'h0;
  logic        cfg_show_target = 1'b1;
  logic [1:0]  cfg_target_bytes = 2'h1;
  logic        stall, got_valid, took;
  logic        stall_seen = 1'b0;
  int          stall_run = 0;
  logic [3:0]  proc_status_port, debug_data_port;
  logic [2:0]  took_kind, got_bytes;
  logic [31:0] got_data;
  logic [34:0] exp_q[$];
  int          fails = 0, comparisons = 0, seed, n, k, v, nbt;

  always #2 core_clk = ~core_clk;

  pts_trace DUT (.core_clk(core_clk), .rst(rst), .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_variant(ev_variant),
    .ev_user(ev_user), .ev_size(ev_size), .ev_data(ev_data), .exc_active(lvl[0]), .emu_exc_active(lvl[1]),
    .stopped(lvl[2]), .halted(lvl[3]), .cfg_show_target(cfg_show_target), .cfg_target_bytes(cfg_target_bytes),
    .stall(stall), .proc_status_port(proc_status_port), .debug_data_port(debug_data_port));
  pts_analyzer u_la (.core_clk(core_clk), .rst(rst), .proc_status_port(proc_status_port),
    .debug_data_port(debug_data_port), .got_valid(got_valid), .got_data(got_data), .got_bytes(got_bytes));

  // ----
  // Expectations
  // ----
  function automatic logic [3:0] code_of(logic [2:0] kd);
    case (kd)
      3'h0: return pts_pkg::PS_BEGIN;
      3'h3: return pts_pkg::PS_BRANCH;
      3'h4: return pts_pkg::PS_EXCRET;
      default: return pts_pkg::PS_PULSE;
    endcase
  endfunction : code_of

  function automatic int nbytes(logic [2:0] kd, logic va, logic [1:0] sz);
    if (kd == 3'h2) return int'(sz) + 1;
    if (kd inside {3'h3, 3'h4} && va && cfg_show_target)
      return (cfg_target_bytes == 2'h0) ? 2 : int'(cfg_target_bytes) + 1;
    return 0;
  endfunction : nbytes

  task automatic check(logic [35:0] got, logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  // Old values are read here, so the take decision matches the design's edge
  always @(posedge core_clk) begin
    took      <= ev_valid && !stall && lvl == 4'h0 && !rst;
    took_kind <= ev_kind;
    // A lone stall only frees a status slot; a long run means a full queue
    stall_run <= (stall === 1'b1) ? stall_run + 1 : 0;
    if (stall_run >= 3) stall_seen <= 1'b1;
    if (ev_valid && !stall && lvl == 4'h0 && !rst) begin
      nbt = nbytes(ev_kind, ev_variant, ev_size);
      if (nbt != 0) exp_q.push_back({3'(nbt), (nbt == 4) ? ev_data : ev_data & ((32'h1 << (8 * nbt)) - 32'h1)});
    end
    if (got_valid === 1'b1) begin
      if (exp_q.size() == 0) check({1'b0, got_bytes, got_data}, 36'h0);
      else check({1'b0, got_bytes, got_data}, {1'b0, exp_q.pop_front()});
    end
  end

  always @(negedge core_clk) begin
    if (took) check(proc_status_port, code_of(took_kind));
  end

  // ----
  // Drivers
  // ----
  task automatic ev(int kd, int va, int us, int sz);
    int i;
    ev_kind    <= 3'(kd);
    ev_variant <= 1'(va);
    ev_user    <= 1'(us);
    ev_size    <= 2'(sz);
    ev_data    <= $random(seed);
    ev_valid   <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge core_clk);
      if (stall === 1'b0) break;
    end
    if (i == 40) fails++;
    @(posedge core_clk);
  endtask : ev

  task automatic mode(logic [3:0] m, logic [3:0] code);
    ev_valid <= 1'b0;
    @(posedge core_clk);
    lvl <= m;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check(proc_status_port, code);
    @(posedge core_clk);
    lvl <= 4'h0;
    repeat (2) @(posedge core_clk);
  endtask : mode

  initial begin
    seed = 99107;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check({stall, proc_status_port, debug_data_port}, 9'h0);
    @(posedge core_clk);
    mode(4'h8, pts_pkg::PS_HALT);
    mode(4'h4, pts_pkg::PS_STOP);
    mode(4'h2, pts_pkg::PS_EMU);
    mode(4'h1, pts_pkg::PS_EXC);
    mode(4'hf, pts_pkg::PS_HALT);
    for (k = 0; k < 5; k++) for (v = 0; v < 2; v++) ev(k, v, k == 1, v);
    for (n = 0; n < 4; n++) begin
      cfg_target_bytes <= 2'(n);
      ev(3, 1, 0, 0);
      ev(2, 0, 0, n);
    end
    repeat (6) ev(2, 0, 0, 3);
    check(stall_seen, 1'b1);
    for (n = 0; n < 300; n++) begin
      cfg_show_target  <= 1'($random(seed));
      cfg_target_bytes <= 2'($random(seed));
      ev($unsigned($random(seed)) % 5, $random(seed) & 1, ($random(seed) & 7) == 0, $random(seed) & 3);
      if (($random(seed) & 3) == 0) begin
        ev_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
      end
    end
    ev_valid <= 1'b0;
    for (n = 0; n < 400 && exp_q.size() != 0; n++) @(posedge core_clk);
    repeat (4) @(negedge core_clk);
    check({exp_q.size() == 0, debug_data_port}, 5'h10);
    summarize();
  end
endmodule : processor_trace_status_port_bench
